// >>> gpio_port_one.sv
// eight-bit general-purpose port with apb register access
// ----------------------------------------------------------------
// What this block does
// - direction bit 1 makes the pin an output, 0 an input.
// - data read on an output pin returns the stored bit.
// - data read on an input pin returns the sampled pin level.
// - direction register is write-only and reads as all ones.
// - direction and data steer the pin only while it is general i/o; direction picks data read-back in both modes.
// - data resets to 00 full, 58 reduced variant.
// - direction resets to 00, all pins inputs.
// - data register at ffd4, read/write, reset 00 full, 58 reduced variant.
// - write-only direction register at ffe4.
// - pull-up control register at ffe0, read/write, reset 00.
// - pin-function register at ffc8, read/write, reset 00.
// - data register is eight bits, one per pin.
// - reduced variant has no pins 6, 4 and 3.
// - pull-up bit enables the pull-up while the pin is a general i/o input.
// - function bit 0 selects general i/o, 1 the alternate function.
// ----------------------------------------------------------------
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_one #(
  parameter bit REDUCED = 1'b0
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // port pins
  input  wire logic [7:0]  bank_one_pin_in,
  output logic [7:0]       bank_one_pin_out,
  output logic [7:0]       bank_one_pin_oe,
  output logic [7:0]       pullup_on,
  // alternate functions
  input  wire logic [7:0]  alt_out,
  input  wire logic [7:0]  alt_oe,
  output logic [7:0]       alt_sel,
  output logic [7:0]       pin_level
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    gpio_port_pkg::bus_phase_t phase;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic [7:0]                pin_data_reg;
    logic [7:0]                pin_direction_reg;
    logic [7:0]                pullup_ctrl_reg;
    logic [7:0]                pin_function_reg;
    logic [7:0]                sample;
    logic [7:0]                pin_out;
    logic [7:0]                pin_oe;
    logic [7:0]                pull_act;
  } state_t;

  localparam logic [7:0] PRESENT = gpio_port_pkg::present_mask(REDUCED);
  localparam logic [7:0] FUNC_WR = PRESENT & ~gpio_port_pkg::FUNC_RSVD;
  localparam logic [7:0] DATA_RV = gpio_port_pkg::data_rst(REDUCED);

  localparam state_t RST_STATE = '{
    phase:             gpio_port_pkg::ph_idle,
    pready:            1'b0,
    pslverr:           1'b0,
    prdata:            32'h0000_0000,
    pin_data_reg:      DATA_RV,
    pin_direction_reg: gpio_port_pkg::DIR_RST,
    pullup_ctrl_reg:   gpio_port_pkg::PULL_RST,
    pin_function_reg:  gpio_port_pkg::FUNC_RST,
    sample:            8'h00,
    pin_out:           8'h00,
    pin_oe:            8'h00,
    pull_act:          8'h00
  };

  state_t s_q;
  state_t s_d;

  logic [7:0]              cell_out;
  logic [7:0]              cell_oe;
  logic [7:0]              cell_pull;
  logic [7:0]              cell_rd;
  logic [7:0]              rd_byte;
  logic                    access;
  gpio_port_pkg::reg_sel_t sel;

  // ----------------------------------------------------------------
  // per-pin steering
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      gpio_pin_cell u_cell (
        .present  (PRESENT[gi]),
        .dir      (s_q.pin_direction_reg[gi]),
        .data     (s_q.pin_data_reg[gi]),
        .func     (s_q.pin_function_reg[gi]),
        .pull     (s_q.pullup_ctrl_reg[gi]),
        .sample   (s_q.sample[gi]),
        .alt_out  (alt_out[gi]),
        .alt_oe   (alt_oe[gi]),
        .drive    (cell_out[gi]),
        .drive_en (cell_oe[gi]),
        .pull_en  (cell_pull[gi]),
        .read_bit (cell_rd[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one wait state: pready rises on the second access cycle, so read
  // data is taken from a register rather than a long address path
  always_comb begin
    s_d    = s_q;
    access = psel & penable;
    sel    = gpio_port_pkg::decode_addr(paddr);
    case (sel)
      gpio_port_pkg::sel_func: rd_byte = s_q.pin_function_reg;
      gpio_port_pkg::sel_data: rd_byte = cell_rd;
      gpio_port_pkg::sel_pull: rd_byte = s_q.pullup_ctrl_reg;
      gpio_port_pkg::sel_dir:  rd_byte = gpio_port_pkg::DIR_READ_VAL;
      default:                 rd_byte = 8'h00;
    endcase
    s_d.sample  = bank_one_pin_in;
    s_d.pin_out = cell_out;
    s_d.pin_oe  = cell_oe;
    s_d.pull_act = cell_pull;
    case (s_q.phase)
      gpio_port_pkg::ph_idle: begin
        if (access) begin
          s_d.phase   = gpio_port_pkg::ph_ack;
          s_d.pready  = 1'b1;
          s_d.pslverr = (sel == gpio_port_pkg::sel_none);
          s_d.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
      end
      gpio_port_pkg::ph_ack: begin
        s_d.phase   = gpio_port_pkg::ph_idle;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0000_0000;
        if (access && pwrite) begin
          case (sel)
            gpio_port_pkg::sel_func: begin
              s_d.pin_function_reg = pwdata[7:0] & FUNC_WR;
            end
            gpio_port_pkg::sel_data: begin
              // absent bits keep their fixed reset ones, whatever is written
              s_d.pin_data_reg = (pwdata[7:0] & PRESENT) | (DATA_RV & ~PRESENT);
            end
            gpio_port_pkg::sel_pull: begin
              s_d.pullup_ctrl_reg = pwdata[7:0] & PRESENT;
            end
            gpio_port_pkg::sel_dir: begin
              s_d.pin_direction_reg = pwdata[7:0] & PRESENT;
            end
            default: begin
              s_d.pin_data_reg = s_q.pin_data_reg;
            end
          endcase
        end
      end
      default: begin
        s_d.phase = gpio_port_pkg::ph_idle;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign prdata           = s_q.prdata;
  assign bank_one_pin_out = s_q.pin_out;
  assign bank_one_pin_oe  = s_q.pin_oe;
  assign pullup_on        = s_q.pull_act;
  assign alt_sel          = s_q.pin_function_reg;
  assign pin_level        = s_q.sample;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic done_rd;
  logic done_wr;
  assign done_rd = psel & penable & pready & ~pwrite;
  assign done_wr = psel & penable & pready & pwrite;

  AST_DIR_READS_ONES: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    done_rd && paddr == gpio_port_pkg::DIR_OFS |-> prdata == 32'h0000_00ff
  ) else $error("direction register did not read as all ones");

  AST_READ_OUTPUT_BITS: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    done_rd && paddr == gpio_port_pkg::DATA_OFS |->
      ((prdata[7:0] ^ s_q.pin_data_reg) & $past(s_q.pin_direction_reg)) == 8'h00
  ) else $error("output pin read did not return stored data");

  AST_READ_INPUT_BITS: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    done_rd && paddr == gpio_port_pkg::DATA_OFS |->
      ((prdata[7:0] ^ $past(s_q.sample)) & ~$past(s_q.pin_direction_reg)
        & PRESENT) == 8'h00
  ) else $error("input pin read did not return the sampled level");

  AST_DRIVE_GATED: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ##1 (bank_one_pin_oe & ~$past(s_q.pin_function_reg)) ==
        ($past(s_q.pin_direction_reg) & ~$past(s_q.pin_function_reg) & PRESENT)
  ) else $error("pin enable does not follow direction in general i/o mode");

  AST_ALT_TAKES_PIN: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ##1 ((bank_one_pin_out ^ $past(alt_out)) & $past(s_q.pin_function_reg))
        == 8'h00
  ) else $error("alternate function does not own its pin");

  AST_PULLUP_INPUT_ONLY: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ##1 (pullup_on & $past(s_q.pin_direction_reg)) == 8'h00
  ) else $error("pull-up on while pin is an output");

  AST_DATA_WRITE: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    done_wr && paddr == gpio_port_pkg::DATA_OFS |=>
      (s_q.pin_data_reg & PRESENT) == ($past(pwdata[7:0]) & PRESENT)
  ) else $error("data register write not stored");

  AST_FUNC_WRITE: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    done_wr && paddr == gpio_port_pkg::FUNC_OFS |=>
      alt_sel == ($past(pwdata[7:0]) & FUNC_WR)
  ) else $error("function register write not seen on alternate select");

  AST_DIR_WRITE: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    done_wr && paddr == gpio_port_pkg::DIR_OFS |=>
      s_q.pin_direction_reg == ($past(pwdata[7:0]) & PRESENT)
  ) else $error("direction register write not stored");

  AST_ABSENT_IDLE: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (bank_one_pin_oe & ~PRESENT) == 8'h00 &&
      (s_q.pin_data_reg & ~PRESENT) == (DATA_RV & ~PRESENT)
  ) else $error("absent pin driven or its fixed bit changed");

  AST_ONE_WAIT: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    psel && penable && !pready |=> pready
  ) else $error("apb answer not given after one wait cycle");

endmodule // gpio_port_one

`default_nettype wire

// >>> gpio_port_pkg.sv
// constants, register map and types shared by the eight-bit port logic
`default_nettype none

package gpio_port_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIN_W  = 8;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] FUNC_OFS = 16'hffc8;
  localparam logic [15:0] DATA_OFS = 16'hffd4;
  localparam logic [15:0] PULL_OFS = 16'hffe0;
  localparam logic [15:0] DIR_OFS  = 16'hffe4;

  // ----------------------------------------------------------------
  // reset values and fixed fields
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_RST_FULL    = 8'h00;
  localparam logic [7:0] DATA_RST_REDUCED = 8'h58;
  localparam logic [7:0] DIR_RST          = 8'h00;
  localparam logic [7:0] PULL_RST         = 8'h00;
  localparam logic [7:0] FUNC_RST         = 8'h00;
  localparam logic [7:0] DIR_READ_VAL     = 8'hff;
  localparam logic [7:0] ABSENT_PINS      = 8'h58;
  localparam logic [7:0] FUNC_RSVD        = 8'h08;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ph_idle = 1'b0,
    ph_ack  = 1'b1
  } bus_phase_t;

  typedef enum logic [2:0] {
    sel_none = 3'b000,
    sel_func = 3'b001,
    sel_data = 3'b010,
    sel_pull = 3'b011,
    sel_dir  = 3'b100
  } reg_sel_t;

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  function automatic logic [7:0] present_mask(input logic reduced);
    return reduced ? ~ABSENT_PINS : 8'hff;
  endfunction

  function automatic logic [7:0] data_rst(input logic reduced);
    return reduced ? DATA_RST_REDUCED : DATA_RST_FULL;
  endfunction

  function automatic reg_sel_t decode_addr(input logic [15:0] addr);
    case (addr)
      FUNC_OFS: return sel_func;
      DATA_OFS: return sel_data;
      PULL_OFS: return sel_pull;
      DIR_OFS:  return sel_dir;
      default:  return sel_none;
    endcase
  endfunction

endpackage

`default_nettype wire

// >>> gpio_pin_cell.sv
// per-pin steering: output drive, enable, pull-up and read-back for one pin
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_cell (
  // configuration
  input  wire logic present,
  input  wire logic dir,
  input  wire logic data,
  input  wire logic func,
  input  wire logic pull,
  // pin and alternate function
  input  wire logic sample,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  // results
  output logic      drive,
  output logic      drive_en,
  output logic      pull_en,
  output logic      read_bit
);

  always_comb begin
    // absent pins never drive and read back their fixed stored value
    if (!present) begin
      drive    = 1'b0;
      drive_en = 1'b0;
      pull_en  = 1'b0;
      read_bit = data;
    end else begin
      drive    = func ? alt_out : data;
      drive_en = func ? alt_oe : dir;
      pull_en  = pull & ~dir & ~func;
      read_bit = dir ? data : sample;
    end
  end

endmodule // gpio_pin_cell

`default_nettype wire

// >>> port_board_model.sv
// board-side model of the eight port pins: resolves each pin level
`timescale 1ns/1ps
`default_nettype none

module port_board_model (
  // clock
  input  wire logic       clk_sys,
  // device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  // board stimulus
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drive,
  // resolved levels
  output logic [7:0]      pin_lvl
);
  logic [7:0] float_q = 8'h55;

  // an undriven line without pull-up toggles so a stale level never passes as valid
  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  // the board lets go of any pin the device drives, so there is no contention
  always_comb begin
    pin_lvl = (pin_oe & pin_out)
            | (~pin_oe & ext_drive & ext_val)
            | (~pin_oe & ~ext_drive & (pullup_on | float_q));
  end
endmodule // port_board_model

`default_nettype wire

// >>> eight_bit_gpio_port_one_bench.sv
// self-checking bench for the eight-bit port with apb register access
`timescale 1ns/1ps
`default_nettype none

module eight_bit_gpio_port_one_bench;
  logic        clk_sys, rst_b, psel, penable, pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [7:0]  alt_out, alt_oe, ext_val, ext_drv;
  logic        tgt, pready_r, pslverr_r, rdy_any, err_any;
  logic [31:0] prdata_r, rd_any;
  logic [7:0]  pin_out_r, pin_oe_r, pullup_on_r, alt_sel_r, pin_level_r, pin_lvl_r;
  logic        pready, pslverr;
  logic [31:0] prdata;
  logic [7:0]  pin_out, pin_oe, pullup_on, alt_sel, pin_level, pin_lvl;
  logic [31:0] exp_d[$];
  logic        exp_e[$];
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  int          seed = 75;

  gpio_port_one #(.REDUCED(1'b0)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel & ~tgt), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .bank_one_pin_in(pin_lvl), .bank_one_pin_out(pin_out), .bank_one_pin_oe(pin_oe),
    .pullup_on(pullup_on), .alt_out(alt_out), .alt_oe(alt_oe), .alt_sel(alt_sel),
    .pin_level(pin_level));

  port_board_model u_board (
    .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_val(ext_val), .ext_drive(ext_drv), .pin_lvl(pin_lvl));

  gpio_port_one #(.REDUCED(1'b1)) u_dut_red (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel & tgt), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready_r), .pslverr(pslverr_r), .prdata(prdata_r),
    .bank_one_pin_in(pin_lvl_r), .bank_one_pin_out(pin_out_r), .bank_one_pin_oe(pin_oe_r),
    .pullup_on(pullup_on_r), .alt_out(alt_out), .alt_oe(alt_oe), .alt_sel(alt_sel_r),
    .pin_level(pin_level_r));

  port_board_model u_board_red (
    .clk_sys(clk_sys), .pin_out(pin_out_r), .pin_oe(pin_oe_r), .pullup_on(pullup_on_r),
    .ext_val(ext_val), .ext_drive(ext_drv), .pin_lvl(pin_lvl_r));

  // the master sees the answer of whichever variant is selected
  assign rdy_any = tgt ? pready_r : pready;
  assign err_any = tgt ? pslverr_r : pslverr;
  assign rd_any  = tgt ? prdata_r : prdata;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     input logic [31:0] ed, input logic ee);
    int n;
    exp_d.push_back(wr ? 32'h0000_0000 : ed);
    exp_e.push_back(ee);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rdy_any !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(32'h0000_0000, 32'h0000_0001);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and response monitor
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && rdy_any === 1'b1 && exp_d.size() > 0) begin
      chk(rd_any, exp_d.pop_front());
      chk({31'h0, err_any}, {31'h0, exp_e.pop_front()});
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [7:0] d, v, p, f, oe, drv, lvl;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    alt_out = 8'h00;
    alt_oe = 8'h00;
    ext_val = 8'h00;
    ext_drv = 8'hff;
    tgt = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk({24'h0, pin_oe}, 32'h0000_0000);
    chk({16'h0000, pullup_on, alt_sel}, 32'h0000_0000);
    apb(1'b0, gpio_port_pkg::FUNC_OFS, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, gpio_port_pkg::DATA_OFS, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, gpio_port_pkg::PULL_OFS, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, gpio_port_pkg::DIR_OFS, 32'h0, 32'h0000_00ff, 1'b0);
    apb(1'b1, 16'hffd0, 32'h0000_00a5, 32'h0, 1'b1);
    apb(1'b0, gpio_port_pkg::DATA_OFS, 32'h0, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      v = 8'($random(seed));
      p = 8'($random(seed));
      f = (i < 4) ? 8'h00 : (8'($random(seed)) & ~gpio_port_pkg::FUNC_RSVD);
      ext_val <= 8'($random(seed));
      alt_out <= 8'($random(seed));
      alt_oe  <= 8'($random(seed));
      ext_drv <= 8'($random(seed)) | ~(p & ~d & ~f);
      apb(1'b1, gpio_port_pkg::DIR_OFS, {24'h0, d}, 32'h0, 1'b0);
      apb(1'b1, gpio_port_pkg::DATA_OFS, {24'h0, v}, 32'h0, 1'b0);
      apb(1'b1, gpio_port_pkg::PULL_OFS, {24'h0, p}, 32'h0, 1'b0);
      apb(1'b1, gpio_port_pkg::FUNC_OFS, {24'h0, f}, 32'h0, 1'b0);
      repeat (4) @(posedge clk_sys);
      oe  = (alt_oe & f) | (d & ~f);
      drv = (alt_out & f) | (v & ~f);
      lvl = (oe & drv) | (~oe & ((ext_drv & ext_val) | ~ext_drv));
      chk({24'h0, pin_oe}, {24'h0, oe});
      chk({24'h0, pin_out & oe}, {24'h0, drv & oe});
      chk({24'h0, pullup_on}, {24'h0, p & ~d & ~f});
      chk({24'h0, alt_sel}, {24'h0, f});
      chk({24'h0, pin_level}, {24'h0, lvl});
      apb(1'b0, gpio_port_pkg::DATA_OFS, 32'h0, {24'h0, (v & d) | (lvl & ~d)}, 1'b0);
      apb(1'b0, gpio_port_pkg::DIR_OFS, 32'h0, 32'h0000_00ff, 1'b0);
      apb(1'b0, gpio_port_pkg::PULL_OFS, 32'h0, {24'h0, p}, 1'b0);
      apb(1'b0, gpio_port_pkg::FUNC_OFS, 32'h0, {24'h0, f}, 1'b0);
    end
    // reduced variant: pins 6, 4 and 3 absent, software keeps their reserved bits except in the ff function write
    tgt     <= 1'b1;
    ext_drv <= 8'hff;
    ext_val <= 8'($random(seed));
    repeat (3) @(posedge clk_sys);
    lvl = (ext_val & ~gpio_port_pkg::ABSENT_PINS) | gpio_port_pkg::DATA_RST_REDUCED;
    apb(1'b0, gpio_port_pkg::DATA_OFS, 32'h0, {24'h0, lvl}, 1'b0);
    d = 8'($random(seed)) & ~gpio_port_pkg::ABSENT_PINS;
    v = 8'($random(seed)) | gpio_port_pkg::ABSENT_PINS;
    f = 8'hff & ~gpio_port_pkg::ABSENT_PINS & ~gpio_port_pkg::FUNC_RSVD;
    apb(1'b1, gpio_port_pkg::DIR_OFS, {24'h0, d}, 32'h0, 1'b0);
    apb(1'b1, gpio_port_pkg::DATA_OFS, {24'h0, v}, 32'h0, 1'b0);
    apb(1'b1, gpio_port_pkg::FUNC_OFS, 32'h0000_00ff, 32'h0, 1'b0);
    chk({24'h0, alt_sel_r}, {24'h0, f});
    apb(1'b0, gpio_port_pkg::FUNC_OFS, 32'h0, {24'h0, f}, 1'b0);
    apb(1'b1, gpio_port_pkg::FUNC_OFS, 32'h0, 32'h0, 1'b0);
    repeat (4) @(posedge clk_sys);
    lvl = (d & v) | (~d & ext_val);
    drv = (v & d) | (lvl & ~d) | gpio_port_pkg::ABSENT_PINS;
    chk({24'h0, pin_oe_r}, {24'h0, d});
    chk({24'h0, pin_out_r & d}, {24'h0, v & d});
    chk({24'h0, pullup_on_r}, 32'h0000_0000);
    chk({24'h0, pin_level_r}, {24'h0, lvl});
    apb(1'b0, gpio_port_pkg::DATA_OFS, 32'h0, {24'h0, drv}, 1'b0);
    repeat (2) @(posedge clk_sys);
    give_verdict();
  end
endmodule // eight_bit_gpio_port_one_bench

`default_nettype wire
